/* hdl/light_threshold_interrupt.sv */
// Purpose: threshold, persistence, wait timer and gain registers
// Assumes: register port is the decoded side of the serial slave
// Notes: read data answers one cycle after the read strobe
`timescale 1ns/1ps
`include "light_consts.svh"
module light_threshold_interrupt
  import light_pkg::*;
#(
  parameter int WAIT_STEP_CYCLES = `WAIT_STEP_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire reg_req_t    reg_req_i,
  input  wire logic        result_valid_i,
  input  wire logic [15:0] vis_result_i,
  input  wire logic        light_interrupt_enable_i,
  input  wire logic        wait_start_i,
  output logic [7:0]       rdata_o,
  output logic             light_interrupt_flag_o,
  output logic             int_o,
  output logic             int_oe_o,
  output logic [6:0]       light_gain_o,
  output logic             wait_busy_o,
  output logic             wait_done_o
);

  localparam logic [15:0] STEP_LAST = 16'(WAIT_STEP_CYCLES - 1);

  core_state_t s_q;
  core_state_t s_d;
  logic        persist_event;
  logic        flag_clear;

  // write strobe to one register address
  function automatic logic wr_hit(input reg_req_t r, input logic [7:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction : wr_hit

  // number of 2.8 ms steps in one wait period
  function automatic logic [11:0] wait_steps(input logic [7:0] w,
                                             input logic       long_w);
    logic [11:0] base;
    base = {4'h0, w} + 12'h001;
    wait_steps = long_w ? 12'(base * `LONG_WAIT_FACTOR) : base;
  endfunction : wait_steps

  // gain factor for the two bit gain code
  function automatic logic [6:0] gain_of(input logic [1:0] code);
    case (code)
      2'h0:    gain_of = 7'h01;
      2'h1:    gain_of = 7'h04;
      2'h2:    gain_of = 7'h10;
      default: gain_of = 7'h40;
    endcase
  endfunction : gain_of

  persistence_counter u_count (
    .clk_i                      (clk_i),
    .reset_i                    (reset_i),
    .result_valid_i             (result_valid_i),
    .vis_result_i               (vis_result_i),
    .low_thr_i                  (s_q.low_thr),
    .high_thr_i                 (s_q.high_thr),
    .persistence_count_select_i (s_q.persistence_filter[3:0]),
    .event_o                    (persist_event),
    .count_o                    ()
  );

  always_comb begin
    s_d = s_q;
    s_d.wait_done = 1'b0;
    s_d.int_lvl = 1'b0;
    flag_clear = wr_hit(reg_req_i, `ADDR_STATUS)
               && reg_req_i.wdata[`FLAG_BIT];
    // register writes
    if (wr_hit(reg_req_i, `ADDR_LOW_THR_LSB)) begin
      s_d.low_stage = reg_req_i.wdata;
    end
    if (wr_hit(reg_req_i, `ADDR_LOW_THR_MSB)) begin
      s_d.low_thr = {reg_req_i.wdata, s_q.low_stage};
    end
    if (wr_hit(reg_req_i, `ADDR_HIGH_THR_LSB)) begin
      s_d.high_stage = reg_req_i.wdata;
    end
    if (wr_hit(reg_req_i, `ADDR_HIGH_THR_MSB)) begin
      s_d.high_thr = {reg_req_i.wdata, s_q.high_stage};
    end
    if (wr_hit(reg_req_i, `ADDR_PERSISTENCE)) begin
      s_d.persistence_filter = reg_req_i.wdata;
    end
    if (wr_hit(reg_req_i, `ADDR_CONFIG_ZERO)) begin
      s_d.config_zero = reg_req_i.wdata;
    end
    if (wr_hit(reg_req_i, `ADDR_CONFIG_ONE)) begin
      s_d.config_one = reg_req_i.wdata;
    end
    if (wr_hit(reg_req_i, `ADDR_WAIT_PERIOD)) begin
      s_d.wait_period_value = reg_req_i.wdata;
    end
    // sticky flag, a new event beats a clear in the same cycle
    s_d.flag = (s_q.flag && !flag_clear) || persist_event;
    s_d.int_oe = s_q.flag && light_interrupt_enable_i;
    s_d.gain = gain_of(s_q.config_one[1:0]);
    // read data
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        `ADDR_WAIT_PERIOD:  s_d.rdata = s_q.wait_period_value;
        `ADDR_LOW_THR_LSB:  s_d.rdata = s_q.low_stage;
        `ADDR_LOW_THR_MSB:  s_d.rdata = s_q.low_thr[15:8];
        `ADDR_HIGH_THR_LSB: s_d.rdata = s_q.high_stage;
        `ADDR_HIGH_THR_MSB: s_d.rdata = s_q.high_thr[15:8];
        `ADDR_PERSISTENCE:  s_d.rdata = s_q.persistence_filter;
        `ADDR_CONFIG_ZERO:  s_d.rdata = s_q.config_zero;
        `ADDR_CONFIG_ONE:   s_d.rdata = s_q.config_one;
        `ADDR_STATUS:       s_d.rdata = {3'h0, s_q.flag, 4'h0};
        default:            s_d.rdata = 8'h00;
      endcase
    end
    // wait timer
    case (s_q.wst)
      WAIT_IDLE: begin
        if (wait_start_i) begin
          s_d.steps = wait_steps(s_q.wait_period_value,
                                 s_q.config_zero[`LONG_WAIT_BIT]);
          s_d.pre = STEP_LAST;
          s_d.wst = WAIT_RUN;
        end
      end
      WAIT_RUN: begin
        if (s_q.pre == 16'h0000) begin
          s_d.pre = STEP_LAST;
          if (s_q.steps == 12'h001) begin
            s_d.wst = WAIT_DONE;
            s_d.wait_done = 1'b1;
          end else begin
            s_d.steps = s_q.steps - 12'h001;
          end
        end else begin
          s_d.pre = s_q.pre - 16'h0001;
        end
      end
      WAIT_DONE: begin
        s_d.wst = WAIT_IDLE;
      end
      default: begin
        s_d.wst = WAIT_IDLE;
      end
    endcase
    // busy is registered so the output comes straight from a flop
    s_d.busy = (s_d.wst == WAIT_RUN);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q            <= '0;
      s_q.low_thr    <= `RST_THRESHOLD;
      s_q.high_thr   <= `RST_THRESHOLD;
      s_q.config_zero <= `RST_CONFIG_ZERO;
      s_q.config_one  <= `RST_BYTE;
      s_q.gain       <= 7'h01;
      s_q.wst        <= WAIT_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o                = s_q.rdata;
  assign light_interrupt_flag_o = s_q.flag;
  assign int_o                  = s_q.int_lvl;
  assign int_oe_o               = s_q.int_oe;
  assign light_gain_o           = s_q.gain;
  assign wait_busy_o            = s_q.busy;
  assign wait_done_o            = s_q.wait_done;

  property p_stage_only;
    @(posedge clk_i) disable iff (reset_i)
    wr_hit(reg_req_i, `ADDR_LOW_THR_LSB)
      && !wr_hit(reg_req_i, `ADDR_LOW_THR_MSB)
      |=> s_q.low_thr == $past(s_q.low_thr);
  endproperty
  a_stage_only: assert property (p_stage_only)
    else $error("low byte write changed active threshold");

  property p_pair_load;
    @(posedge clk_i) disable iff (reset_i)
    wr_hit(reg_req_i, `ADDR_HIGH_THR_LSB) ##1 !reg_req_i.wr ##1
      wr_hit(reg_req_i, `ADDR_HIGH_THR_MSB)
      |=> s_q.high_thr[7:0] == $past(reg_req_i.wdata, 3)
       && s_q.high_thr[15:8] == $past(reg_req_i.wdata);
  endproperty
  a_pair_load: assert property (p_pair_load)
    else $error("threshold pair not loaded together");

  property p_pin;
    @(posedge clk_i) disable iff (reset_i)
    ##1 int_oe_o == $past(s_q.flag && light_interrupt_enable_i);
  endproperty
  a_pin: assert property (p_pin)
    else $error("interrupt pin does not follow flag and enable");

  property p_clear;
    @(posedge clk_i) disable iff (reset_i)
    flag_clear && !persist_event |=> !light_interrupt_flag_o;
  endproperty
  a_clear: assert property (p_clear)
    else $error("flag not cleared by write one");

  property p_set_wins;
    @(posedge clk_i) disable iff (reset_i)
    persist_event |=> light_interrupt_flag_o;
  endproperty
  a_set_wins: assert property (p_set_wins)
    else $error("persistence event lost");

  property p_gain;
    @(posedge clk_i) disable iff (reset_i)
    s_q.config_one[1:0] == 2'h2 |=> light_gain_o == 7'h10;
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain code two not sixteen");

  property p_short_wait;
    @(posedge clk_i) disable iff (reset_i)
    s_q.wst == WAIT_IDLE && wait_start_i && !s_q.config_zero[`LONG_WAIT_BIT]
      |=> s_q.steps == {4'h0, $past(s_q.wait_period_value)} + 12'h001;
  endproperty
  a_short_wait: assert property (p_short_wait)
    else $error("wait steps not value plus one");

  property p_long_wait;
    @(posedge clk_i) disable iff (reset_i)
    s_q.wst == WAIT_IDLE && wait_start_i && s_q.config_zero[`LONG_WAIT_BIT]
      |=> s_q.steps
          == 12'(({4'h0, $past(s_q.wait_period_value)} + 12'h001) * 12'h00c);
  endproperty
  a_long_wait: assert property (p_long_wait)
    else $error("long wait not twelve times");

endmodule : light_threshold_interrupt

/* hdl/light_consts.svh */
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 10 MHz core clock, byte wide register port
// Notes: shared by the light threshold interrupt block
// Function
// - a visible result below the low threshold counts as out of range.
// - a visible result above the high threshold counts as out of range.
// - the interrupt pin is driven active while the flag and enable are set.
// - a threshold low byte is staged and loaded with its high byte write.
// - persistence 0 flags every result and 1 flags the first out of range.
// - persistence 2 to 7 need 2,3,5,10,15,20 and 13 to 15 need 50,55,60.
// - the flag sets when the out of range count equals the selected number.
// - a result inside the threshold window clears the out of range count.
// - the wait period is a down count of wait value plus one 2.8 ms steps.
// - config zero bit 2 set makes the programmed wait 12 times longer.
// - the gain field selects 1x, 4x, 16x or 64x for codes 0 to 3.
// - writing a one to a status flag bit clears that flag.
`ifndef LIGHT_CONSTS_SVH
`define LIGHT_CONSTS_SVH

`define ADDR_WAIT_PERIOD    8'h83
`define ADDR_LOW_THR_LSB    8'h84
`define ADDR_LOW_THR_MSB    8'h85
`define ADDR_HIGH_THR_LSB   8'h86
`define ADDR_HIGH_THR_MSB   8'h87
`define ADDR_PERSISTENCE    8'h8c
`define ADDR_CONFIG_ZERO    8'h8d
`define ADDR_CONFIG_ONE     8'h90
`define ADDR_STATUS         8'h93

`define RST_BYTE            8'h00
`define RST_CONFIG_ZERO     8'h80
`define RST_THRESHOLD       16'h0000

`define LONG_WAIT_BIT       2
`define FLAG_BIT            4
`define LONG_WAIT_FACTOR    12'h00c

`define CLK_PERIOD_NS       100
`define WAIT_STEP_NS        2800000
`define WAIT_STEP_CYCLES    (`WAIT_STEP_NS / `CLK_PERIOD_NS)

`endif

/* hdl/light_pkg.sv */
// Purpose: types of the light threshold interrupt block
// Assumes: constants live in light_consts.svh
// Notes: none
package light_pkg;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    WAIT_IDLE = 2'b00,
    WAIT_RUN  = 2'b01,
    WAIT_DONE = 2'b11
  } wait_state_t;

  typedef struct packed {
    logic [5:0] count;
    logic       event_hit;
  } counter_state_t;

  typedef struct packed {
    logic [7:0]  low_stage;
    logic [15:0] low_thr;
    logic [7:0]  high_stage;
    logic [15:0] high_thr;
    logic [7:0]  persistence_filter;
    logic [7:0]  config_zero;
    logic [7:0]  config_one;
    logic [7:0]  wait_period_value;
    logic        flag;
    logic        int_oe;
    logic        int_lvl;
    logic [6:0]  gain;
    logic [7:0]  rdata;
    wait_state_t wst;
    logic [15:0] pre;
    logic [11:0] steps;
    logic        wait_done;
    logic        busy;
  } core_state_t;

endpackage : light_pkg

/* hdl/persistence_counter.sv */
// Purpose: counts consecutive out of range visible results
// Assumes: result_valid_i pulses once per conversion
// Notes: count saturates at its top value
`timescale 1ns/1ps
`include "light_consts.svh"
module persistence_counter
  import light_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire logic        result_valid_i,
  input  wire logic [15:0] vis_result_i,
  input  wire logic [15:0] low_thr_i,
  input  wire logic [15:0] high_thr_i,
  input  wire logic [3:0]  persistence_count_select_i,
  output logic             event_o,
  output logic [5:0]       count_o
);

  counter_state_t s_q;
  counter_state_t s_d;
  logic           out_range;
  logic [5:0]     next_count;

  // results needed before the flag sets
  function automatic logic [5:0] needed(input logic [3:0] sel);
    case (sel)
      4'h0:    needed = 6'h00;
      4'h1:    needed = 6'h01;
      4'h2:    needed = 6'h02;
      4'h3:    needed = 6'h03;
      4'h4:    needed = 6'h05;
      4'h5:    needed = 6'h0a;
      4'h6:    needed = 6'h0f;
      4'h7:    needed = 6'h14;
      4'h8:    needed = 6'h19;
      4'h9:    needed = 6'h1e;
      4'ha:    needed = 6'h23;
      4'hb:    needed = 6'h28;
      4'hc:    needed = 6'h2d;
      4'hd:    needed = 6'h32;
      4'he:    needed = 6'h37;
      default: needed = 6'h3c;
    endcase
  endfunction : needed

  always_comb begin
    out_range = (vis_result_i < low_thr_i)
              | (vis_result_i > high_thr_i);
    next_count = (s_q.count == 6'h3f) ? s_q.count : s_q.count + 6'h01;
    s_d = s_q;
    s_d.event_hit = 1'b0;
    if (result_valid_i) begin
      if (out_range) begin
        s_d.count = next_count;
      end else begin
        s_d.count = 6'h00;
      end
      if (persistence_count_select_i == 4'h0) begin
        s_d.event_hit = 1'b1;
      end else if (out_range
                   && next_count == needed(persistence_count_select_i)) begin
        s_d.event_hit = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign event_o = s_q.event_hit;
  assign count_o = s_q.count;

  property p_in_window;
    @(posedge clk_i) disable iff (reset_i)
    result_valid_i && !out_range |=> count_o == 6'h00;
  endproperty
  a_in_window: assert property (p_in_window)
    else $error("count not cleared inside window");

  property p_below_low;
    @(posedge clk_i) disable iff (reset_i)
    result_valid_i && vis_result_i < low_thr_i && count_o < 6'h3e
      |=> count_o == $past(count_o) + 6'h01;
  endproperty
  a_below_low: assert property (p_below_low)
    else $error("low side result not counted");

  property p_above_high;
    @(posedge clk_i) disable iff (reset_i)
    result_valid_i && vis_result_i > high_thr_i && count_o < 6'h3e
      |=> count_o == $past(count_o) + 6'h01;
  endproperty
  a_above_high: assert property (p_above_high)
    else $error("high side result not counted");

  property p_every_cycle;
    @(posedge clk_i) disable iff (reset_i)
    result_valid_i && persistence_count_select_i == 4'h0 |=> event_o;
  endproperty
  a_every_cycle: assert property (p_every_cycle)
    else $error("persistence zero did not flag");

  property p_sel_seven;
    @(posedge clk_i) disable iff (reset_i)
    result_valid_i && out_range && persistence_count_select_i == 4'h7
      && count_o == 6'h13 |=> event_o;
  endproperty
  a_sel_seven: assert property (p_sel_seven)
    else $error("twentieth result did not flag");

  property p_sel_eight;
    @(posedge clk_i) disable iff (reset_i)
    result_valid_i && out_range && persistence_count_select_i == 4'h8
      && count_o == 6'h18 |=> event_o;
  endproperty
  a_sel_eight: assert property (p_sel_eight)
    else $error("twenty fifth result did not flag");

  property p_no_early;
    @(posedge clk_i) disable iff (reset_i)
    result_valid_i && persistence_count_select_i != 4'h0
      && s_d.count != needed(persistence_count_select_i)
      |=> !event_o;
  endproperty
  a_no_early: assert property (p_no_early)
    else $error("flag raised off the selected count");

endmodule : persistence_counter

/* verification/light_host.sv */
// Purpose: host side model of the register port
// Assumes: strobes change on the falling clock edge
// Notes: one write every two cycles, one read every three, threshold bytes lsb first
`timescale 1ns/1ps
`include "light_consts.svh"
module light_host
  import light_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic [7:0] rdata_i,
  output reg_req_t        req_o
);
  initial req_o = '0;

  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_i);
    req_o = '0;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_i);
    req_o = '0;
    @(negedge clk_i);
    d = rdata_i;
  endtask : read_reg

  // low byte first, matching high byte as the very next access
  task automatic thr_write(input logic [7:0] a, input logic [15:0] v);
    write_reg(a, v[7:0]);
    write_reg(a + 8'h01, v[15:8]);
  endtask : thr_write

  // reserved fields kept at their default pattern
  task automatic config_zero_write(input logic long_w);
    write_reg(`ADDR_CONFIG_ZERO, {5'h10, long_w, 2'h0});
  endtask : config_zero_write
endmodule : light_host

/* verification/light_threshold_interrupt_tb.sv */
// Purpose: self checking bench of the light threshold interrupt block
// Assumes: inputs change on the falling edge, short wait step
// Notes: host model drives the register port
`timescale 1ns/1ps
`include "light_consts.svh"
module light_threshold_interrupt_tb;
  import light_pkg::*;
  localparam int STEP  = 3;
  localparam int LIMIT = 20000;
  logic        clk_i;
  logic        reset_i;
  reg_req_t    reg_req_i;
  logic        result_valid_i;
  logic [15:0] vis_result_i;
  logic        light_interrupt_enable_i;
  logic        wait_start_i;
  logic [7:0]  rdata_o;
  logic        light_interrupt_flag_o;
  logic        int_o;
  logic        int_oe_o;
  logic [6:0]  light_gain_o;
  logic        wait_busy_o;
  logic        wait_done_o;
  int          mismatches;
  int          total_checks;
  int          cycles;

  light_threshold_interrupt #(.WAIT_STEP_CYCLES(STEP)) u_dut (
    .clk_i(clk_i), .reset_i(reset_i), .reg_req_i(reg_req_i),
    .result_valid_i(result_valid_i), .vis_result_i(vis_result_i),
    .light_interrupt_enable_i(light_interrupt_enable_i),
    .wait_start_i(wait_start_i), .rdata_o(rdata_o),
    .light_interrupt_flag_o(light_interrupt_flag_o), .int_o(int_o),
    .int_oe_o(int_oe_o), .light_gain_o(light_gain_o),
    .wait_busy_o(wait_busy_o), .wait_done_o(wait_done_o)
  );
  light_host u_host (.clk_i(clk_i), .rdata_i(rdata_o), .req_o(reg_req_i));

  initial clk_i = 1'b0;
  always #50 clk_i = ~clk_i;

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp,
                     input string msg);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop

  always @(posedge clk_i) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      report_and_stop();
    end
  end

  task automatic push(input logic [15:0] v);
    @(negedge clk_i);
    result_valid_i = 1'b1;
    vis_result_i   = v;
    @(negedge clk_i);
    result_valid_i = 1'b0;
  endtask : push

  task automatic settle();
    repeat (3) @(negedge clk_i);
  endtask : settle

  task automatic clear_flag();
    u_host.write_reg(`ADDR_STATUS, 8'h10);
    settle();
    chk(light_interrupt_flag_o, 0, "flag clear");
  endtask : clear_flag

  task automatic test_reset();
    logic [7:0] d;
    logic [7:0] ad[8] = '{8'h84, 8'h85, 8'h86, 8'h87, 8'h8c, 8'h8d, 8'h90,
                          8'ha0};
    logic [7:0] ex[8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h00,
                          8'h00};
    for (int i = 0; i < 8; i++) begin
      u_host.read_reg(ad[i], d);
      chk(d, ex[i], "reset read");
    end
    chk(light_gain_o, 1, "reset gain");
    chk(light_interrupt_flag_o, 0, "reset flag");
    chk(int_oe_o, 0, "reset pin");
    $display("test reset done");
  endtask : test_reset

  task automatic test_thresholds();
    logic [7:0] d;
    u_host.write_reg(`ADDR_PERSISTENCE, 8'h01);
    u_host.thr_write(`ADDR_LOW_THR_LSB, 16'h0180);
    u_host.thr_write(`ADDR_HIGH_THR_LSB, 16'h0300);
    u_host.write_reg(`ADDR_LOW_THR_LSB, 8'h00);
    push(16'h0150);
    settle();
    chk(light_interrupt_flag_o, 1, "staged low byte leaked");
    clear_flag();
    u_host.write_reg(`ADDR_LOW_THR_MSB, 8'h01);
    push(16'h0150);
    settle();
    chk(light_interrupt_flag_o, 0, "pair not loaded");
    u_host.read_reg(`ADDR_LOW_THR_MSB, d);
    chk(d, 8'h01, "low msb readback");
    push(16'h0100);
    push(16'h0300);
    settle();
    chk(light_interrupt_flag_o, 0, "edge values");
    push(16'h00ff);
    settle();
    chk(light_interrupt_flag_o, 1, "below low");
    u_host.read_reg(`ADDR_STATUS, d);
    chk(d, 8'h10, "status flag bit");
    clear_flag();
    push(16'h0200);
    push(16'h0301);
    settle();
    chk(light_interrupt_flag_o, 1, "above high");
    light_interrupt_enable_i = 1'b1;
    settle();
    chk(int_oe_o, 1, "pin enabled");
    chk(int_o, 0, "pin level");
    light_interrupt_enable_i = 1'b0;
    settle();
    chk(int_oe_o, 0, "pin masked");
    clear_flag();
    $display("test thresholds done");
  endtask : test_thresholds

  task automatic test_every_result();
    u_host.write_reg(`ADDR_PERSISTENCE, 8'h00);
    push(16'h0200);
    settle();
    chk(light_interrupt_flag_o, 1, "every cycle");
    clear_flag();
    $display("test every result done");
  endtask : test_every_result

  task automatic test_count_table();
    int need[16] = '{1, 1, 2, 3, 5, 10, 15, 20, 25, 30, 35, 40, 45, 50, 55,
                     60};
    for (int c = 2; c < 16; c++) begin
      u_host.write_reg(`ADDR_PERSISTENCE, 8'(c));
      push(16'h0200);
      repeat (need[c] - 1) push(16'h0400);
      settle();
      chk(light_interrupt_flag_o, 0, "early flag");
      push(16'h0200);
      repeat (need[c] - 1) push(16'h0400);
      settle();
      chk(light_interrupt_flag_o, 0, "count not cleared");
      push(16'h0400);
      settle();
      chk(light_interrupt_flag_o, 1, "count reached");
      clear_flag();
    end
    $display("test count table done");
  endtask : test_count_table

  task automatic test_wait();
    int n;
    int lo;
    u_host.write_reg(`ADDR_WAIT_PERIOD, 8'h02);
    for (int lw = 0; lw < 2; lw++) begin
      u_host.config_zero_write(lw[0]);
      lo = 3 * STEP * (lw == 1 ? 12 : 1);
      @(negedge clk_i);
      wait_start_i = 1'b1;
      @(negedge clk_i);
      wait_start_i = 1'b0;
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
        if (n == 1) chk(wait_busy_o, 1, "busy");
      end while (wait_done_o !== 1'b1 && n < 2000);
      chk(16'(n >= lo && n <= lo + 2), 1, "wait length");
    end
    $display("test wait done");
  endtask : test_wait

  task automatic test_gain();
    logic [7:0] d;
    logic [6:0] g[4] = '{7'h01, 7'h04, 7'h10, 7'h40};
    for (int i = 0; i < 4; i++) begin
      u_host.write_reg(`ADDR_CONFIG_ONE, 8'(i));
      settle();
      chk(light_gain_o, g[i], "gain");
      u_host.read_reg(`ADDR_CONFIG_ONE, d);
      chk(d, 8'(i), "gain code readback");
    end
    $display("test gain done");
  endtask : test_gain

  initial begin
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    reset_i = 1'b1;
    result_valid_i = 1'b0;
    vis_result_i = 16'h0000;
    light_interrupt_enable_i = 1'b0;
    wait_start_i = 1'b0;
    repeat (20) @(negedge clk_i);
    reset_i = 1'b0;
    test_reset();
    test_thresholds();
    test_every_result();
    test_count_table();
    test_wait();
    test_gain();
    report_and_stop();
  end
endmodule : light_threshold_interrupt_tb
